// ===== hw/mis_word_sequencer.v
// Channel sequencer and host word formatter for a 16-channel 12-bit input module
//
// What this block and the host do
// RULE1: Channel count is jumper sum plus one
// RULE2: Only first N channels are processed
// RULE3: Range jumper per bank, installed means 10V
// RULE4: Default range is 10V on all channels
// RULE5: One channel presented per host scan
// RULE6: Wrap to channel 1 after the last
// RULE7: Convert continuously, deliver only at scans
// RULE8: Host sees one 16-bit word
// RULE9: Top four bits are channel minus one
// RULE10: Code refreshed with data every scan
// RULE11: Low twelve bits unsigned binary sample
// RULE12: Range ends map to counts 0 and 4095
// RULE13: Host maps points on word boundary
// RULE14: Host masks code bits before use
// RULE15: First word after reset is channel 1
`timescale 1ns/100ps
`include "mis_defines.vh"

module mis_word_sequencer (
  input wire clk_sys, // System clock, 25 MHz
  input wire reset_n, // Asynchronous reset, active low
  input wire [3:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output wire s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write byte strobes
  input wire s_axi_wvalid, // Write data valid
  output wire s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [3:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output wire s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire [3:0] countJumper, // Count jumpers +8 +4 +2 +1, high = installed
  input wire rangeLowJumper, // Channels 1-8 range, high = 10V
  input wire rangeHighJumper, // Channels 9-16 range, high = 10V
  output reg [3:0] convChannel, // Mux channel for the converter
  output reg convRange10V, // Front-end range select, high = 10V
  output reg convStart, // Conversion start pulse
  input wire convDone, // Conversion done level from converter
  input wire [11:0] convData, // Converter result, unsigned
  input wire hostScan, // Host scan update strobe
  output reg [15:0] hostWord // Word read by the host
);

  localparam ST_IDLE = 3'h1;
  localparam ST_START = 3'h2;
  localparam ST_WAIT = 3'h4;

  reg [3:0] countSync1_reg, countSync2_reg;
  reg [1:0] rangeSync1_reg, rangeSync2_reg;
  reg doneSync1_reg, doneSync2_reg, donePrev_reg;
  reg [11:0] dataSync1_reg, dataSync2_reg;
  reg scanSync1_reg, scanSync2_reg, scanPrev_reg;
  reg [1:0] ctrl_reg;
  reg [31:0] scans_reg;
  reg [2:0] state_reg;
  reg [3:0] convChan_reg, seqChan_reg;
  reg [15:0] fifoMem0_reg, fifoMem1_reg;
  reg fifoWrPtr_reg, fifoRdPtr_reg;
  reg [1:0] fifoCount_reg;
  wire [3:0] lastChan;
  wire doneRise, scanRise, wrTake, rdTake;
  wire fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
  wire [15:0] fifoInData, fifoOutData, nextWord;
  wire [11:0] sampleWord [0:15];
  reg [31:0] readData;
  reg [1:0] readResp;

  // Two-stage synchronisers for the jumper, converter and scan inputs
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      countSync1_reg <= `MIS_COUNT_RESET; // RULE4
      countSync2_reg <= `MIS_COUNT_RESET;
      rangeSync1_reg <= {2{`MIS_RANGE_RESET}}; // RULE4
      rangeSync2_reg <= {2{`MIS_RANGE_RESET}}; // RULE4
      doneSync1_reg <= 1'h0;
      doneSync2_reg <= 1'h0;
      donePrev_reg <= 1'h0;
      dataSync1_reg <= 12'h000;
      dataSync2_reg <= 12'h000;
      scanSync1_reg <= 1'h0;
      scanSync2_reg <= 1'h0;
      scanPrev_reg <= 1'h0;
    end
    else
    begin
      countSync1_reg <= countJumper;
      countSync2_reg <= countSync1_reg;
      rangeSync1_reg <= {rangeHighJumper, rangeLowJumper};
      rangeSync2_reg <= rangeSync1_reg;
      doneSync1_reg <= convDone;
      doneSync2_reg <= doneSync1_reg;
      donePrev_reg <= doneSync2_reg;
      dataSync1_reg <= convData;
      dataSync2_reg <= dataSync1_reg;
      scanSync1_reg <= hostScan;
      scanSync2_reg <= scanSync1_reg;
      scanPrev_reg <= scanSync2_reg;
    end
  end

  // Last active channel index equals the jumper sum
  assign lastChan = countSync2_reg; // RULE1
  assign doneRise = doneSync2_reg & ~donePrev_reg;
  assign scanRise = scanSync2_reg & ~scanPrev_reg;

  // Free-running conversion sequencer over the active channels
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= ST_IDLE;
      convChan_reg <= `MIS_FIRST_CHAN;
      convChannel <= `MIS_FIRST_CHAN;
      convRange10V <= `MIS_RANGE_RESET;
      convStart <= 1'h0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          convStart <= 1'h0;
          // Start only when the buffer can hold the result
          if (ctrl_reg[`MIS_CTRL_RUN] && fifoInReady) // RULE7
          begin
            convChannel <= convChan_reg;
            convStart <= 1'h1;
            if (convChan_reg < `MIS_BANK_SPLIT)
              convRange10V <= rangeSync2_reg[0]; // RULE3
            else
              convRange10V <= rangeSync2_reg[1]; // RULE3
            state_reg <= ST_START;
          end
        end
        ST_START:
        begin
          convStart <= 1'h0;
          state_reg <= ST_WAIT;
        end
        ST_WAIT:
        begin
          convStart <= 1'h0;
          if (doneRise)
          begin
            // Skip channels above the jumper count
            if (convChan_reg >= lastChan) // RULE2
              convChan_reg <= `MIS_FIRST_CHAN;
            else
              convChan_reg <= convChan_reg + 4'h1;
            state_reg <= ST_IDLE;
          end
        end
        default:
        begin
          convStart <= 1'h0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Result pushed as channel tag plus unsigned sample
  assign fifoInValid = (state_reg == ST_WAIT) && doneRise;
  assign fifoInData = {convChan_reg, dataSync2_reg}; // RULE11 RULE12

  // Two-entry result buffer; freeze stalls the drain side
  assign fifoInReady = (fifoCount_reg != `MIS_FIFO_DEPTH);
  assign fifoOutValid = (fifoCount_reg != 2'h0);
  assign fifoOutReady = ~ctrl_reg[`MIS_CTRL_FREEZE];
  assign fifoOutData = fifoRdPtr_reg ? fifoMem1_reg : fifoMem0_reg;

  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fifoMem0_reg <= 16'h0000;
      fifoMem1_reg <= 16'h0000;
      fifoWrPtr_reg <= 1'h0;
      fifoRdPtr_reg <= 1'h0;
      fifoCount_reg <= 2'h0;
    end
    else
    begin
      if (fifoInValid && fifoInReady)
      begin
        if (fifoWrPtr_reg)
          fifoMem1_reg <= fifoInData;
        else
          fifoMem0_reg <= fifoInData;
        fifoWrPtr_reg <= ~fifoWrPtr_reg;
      end
      if (fifoOutValid && fifoOutReady)
        fifoRdPtr_reg <= ~fifoRdPtr_reg;
      case ({fifoInValid && fifoInReady, fifoOutValid && fifoOutReady})
        2'b10: fifoCount_reg <= fifoCount_reg + 2'h1;
        2'b01: fifoCount_reg <= fifoCount_reg - 2'h1;
        default: fifoCount_reg <= fifoCount_reg;
      endcase
    end
  end

  // Latest sample per channel, written as results drain
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : gSample
      localparam [3:0] CHAN_IDX = gi; // Channel code this slot answers to
      reg [11:0] sample_reg;
      always @(posedge clk_sys or negedge reset_n)
      begin
        if (!reset_n)
          sample_reg <= 12'h000;
        else if (fifoOutValid && fifoOutReady &&
                 fifoOutData[`MIS_CODE_MSB:`MIS_CODE_LSB] == CHAN_IDX)
          sample_reg <= fifoOutData[`MIS_DATA_MSB:0]; // RULE7
      end
      assign sampleWord[gi] = sample_reg;
    end
  endgenerate

  // Code and sample taken together so they always match
  assign nextWord = {seqChan_reg, sampleWord[seqChan_reg]}; // RULE8 RULE9 RULE10 RULE11

  // Host word update, one channel per scan
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      seqChan_reg <= `MIS_FIRST_CHAN; // RULE15
      hostWord <= 16'h0000;
      scans_reg <= 32'h00000000;
    end
    else if (scanRise)
    begin
      hostWord <= nextWord; // RULE5 RULE10
      scans_reg <= scans_reg + 32'h00000001;
      if (seqChan_reg >= lastChan) // RULE2
        seqChan_reg <= `MIS_FIRST_CHAN; // RULE6
      else
        seqChan_reg <= seqChan_reg + 4'h1; // RULE5
    end
  end

  // Write channels taken together, one response outstanding
  assign wrTake = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wrTake;
  assign s_axi_wready = wrTake;

  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_reg <= `MIS_CTRL_RESET;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= `MIS_RESP_OKAY;
    end
    else
    begin
      if (wrTake)
      begin
        s_axi_bvalid <= 1'h1;
        case (s_axi_awaddr)
          `MIS_OFS_CTRL:
          begin
            s_axi_bresp <= `MIS_RESP_OKAY;
            if (s_axi_wstrb[0])
              ctrl_reg <= s_axi_wdata[1:0];
          end
          `MIS_OFS_STATUS, `MIS_OFS_WORD, `MIS_OFS_SCANS:
            s_axi_bresp <= `MIS_RESP_OKAY;
          default:
            s_axi_bresp <= `MIS_RESP_SLVERR;
        endcase
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'h0;
    end
  end

  // Read decode
  always @*
  begin
    readData = 32'h00000000;
    readResp = `MIS_RESP_OKAY;
    case (s_axi_araddr)
      `MIS_OFS_CTRL: readData[1:0] = ctrl_reg;
      `MIS_OFS_STATUS:
      begin
        readData[`MIS_ST_COUNT_MSB:`MIS_ST_COUNT_LSB] = lastChan;
        readData[`MIS_ST_RANGE_LO] = rangeSync2_reg[0];
        readData[`MIS_ST_RANGE_HI] = rangeSync2_reg[1];
        readData[`MIS_ST_FULL] = ~fifoInReady;
        readData[`MIS_ST_CHAN_MSB:`MIS_ST_CHAN_LSB] = seqChan_reg;
      end
      `MIS_OFS_WORD: readData[15:0] = hostWord;
      `MIS_OFS_SCANS: readData = scans_reg;
      default: readResp = `MIS_RESP_SLVERR;
    endcase
  end

  // Read channel, one answer outstanding
  assign rdTake = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = rdTake;

  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `MIS_RESP_OKAY;
    end
    else if (rdTake)
    begin
      s_axi_rvalid <= 1'h1;
      s_axi_rdata <= readData;
      s_axi_rresp <= readResp;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'h0;
  end

endmodule // mis_word_sequencer

// ===== inc/mis_defines.vh
// Constants for the multiplexed input word sequencer
`ifndef MIS_DEFINES_VH
`define MIS_DEFINES_VH

// Register byte offsets
`define MIS_OFS_CTRL 4'h0
`define MIS_OFS_STATUS 4'h4
`define MIS_OFS_WORD 4'h8
`define MIS_OFS_SCANS 4'hc

// Control field positions and reset value
`define MIS_CTRL_RUN 0
`define MIS_CTRL_FREEZE 1
`define MIS_CTRL_RESET 2'h1

// Status field positions
`define MIS_ST_COUNT_LSB 0
`define MIS_ST_COUNT_MSB 3
`define MIS_ST_RANGE_LO 4
`define MIS_ST_RANGE_HI 5
`define MIS_ST_FULL 6
`define MIS_ST_CHAN_LSB 8
`define MIS_ST_CHAN_MSB 11

// Host word layout
`define MIS_CODE_MSB 15
`define MIS_CODE_LSB 12
`define MIS_DATA_MSB 11

// Jumper reset values: factory state, all installed
`define MIS_COUNT_RESET 4'hf
`define MIS_RANGE_RESET 1'h1

// Sequencing constants
`define MIS_FIRST_CHAN 4'h0
`define MIS_BANK_SPLIT 4'h8
`define MIS_FIFO_DEPTH 2'h2

// Bus responses
`define MIS_RESP_OKAY 2'h0
`define MIS_RESP_SLVERR 2'h2

`endif

// ===== sim/mis_seq_monitor.sv
// Port assertions for the word sequencer
`timescale 1ns/100ps

module mis_seq_monitor (
  input wire clk_sys, // Clock
  input wire reset_n, // Reset
  input wire s_axi_awvalid, // Aw valid
  input wire s_axi_wvalid, // W valid
  input wire s_axi_bvalid, // B valid
  input wire s_axi_bready, // B ready
  input wire [1:0] s_axi_bresp, // B resp
  input wire s_axi_arvalid, // Ar valid
  input wire s_axi_rvalid, // R valid
  input wire s_axi_rready, // R ready
  input wire [31:0] s_axi_rdata, // R data
  input wire [3:0] countJumper, // Count pins
  input wire rangeLowJumper, // Low bank pin
  input wire rangeHighJumper, // High bank pin
  input wire [3:0] convChannel, // Channel
  input wire convRange10V, // Range
  input wire convStart, // Start
  input wire hostScan, // Scan
  input wire [15:0] hostWord // Word
);
  // Single domain
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // Bus answers and holds
  chk_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
    |=> s_axi_bvalid) else $error("write not answered");
  chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid
    |=> s_axi_rvalid) else $error("read not answered");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");

  // Converter side
  chk_start_pulse: assert property (
    convStart |=> !convStart) else $error("start longer than a cycle");
  chk_no_skip: assert property (
    $past(reset_n, 4) && convStart |-> convChannel <= countJumper)
    else $error("inactive channel converted");
  chk_range_bank: assert property (
    $past(reset_n, 4) && convStart
    |-> convRange10V == (convChannel[3] ? rangeHighJumper : rangeLowJumper))
    else $error("wrong bank range");

  // Host word
  chk_word_timing: assert property (
    $changed(hostWord) |-> $past(hostScan, 3)) else $error("word moved off scan");
  chk_code_step: assert property (
    $changed(hostWord[15:12]) |-> hostWord[15:12] == 4'h0
    || hostWord[15:12] - $past(hostWord[15:12]) == 4'h1) else $error("code skipped");
endmodule // mis_seq_monitor

bind mis_word_sequencer mis_seq_monitor u_mon (.clk_sys, .reset_n, .s_axi_awvalid,
  .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .countJumper, .rangeLowJumper, .rangeHighJumper,
  .convChannel, .convRange10V, .convStart, .hostScan, .hostWord);

// ===== sim/mis_conv_model.sv
// Behavioural converter answering start pulses
`timescale 1ns/100ps

module mis_conv_model (
  input wire clk_sys, // Clock
  input wire [3:0] convChannel, // Channel
  input wire convRange10V, // Range
  input wire convStart, // Start
  input wire slowMode, // Long conversions
  output logic convDone, // Done level
  output logic [11:0] convData // Result
);
  // Result tags range and channel; stale data inverted
  initial
  begin
    convDone = 1'h0;
    convData = 12'h000;
    forever
    begin
      @(posedge clk_sys);
      if (convStart === 1'h1)
      begin
        repeat (slowMode ? 40 : 2) @(posedge clk_sys);
        convData <= {convRange10V, 3'h0, convChannel, 4'ha};
        @(posedge clk_sys);
        convDone <= 1'h1;
        repeat (3) @(posedge clk_sys); // Short done so the next start is caught
        convDone <= 1'h0;
        convData <= ~convData;
      end
    end
  end
endmodule // mis_conv_model

// ===== sim/mis_word_sequencer_tb_top.sv
// Self-checking bench for the word sequencer
`timescale 1ns/100ps

module mis_word_sequencer_tb_top;
  logic clk_sys = 1'h0, reset_n = 1'h0, slowMode = 1'h0, hostScan = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic rangeLowJumper = 1'h1, rangeHighJumper = 1'h1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [3:0] countJumper = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire convRange10V, convStart, convDone;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] convChannel;
  wire [11:0] convData;
  wire [15:0] hostWord;
  int err_total = 0, n_tests = 0;

  mis_word_sequencer dut (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .countJumper, .rangeLowJumper, .rangeHighJumper,
    .convChannel, .convRange10V, .convStart, .convDone, .convData, .hostScan, .hostWord);
  mis_conv_model conv (.clk_sys, .convChannel, .convRange10V, .convStart, .slowMode,
    .convDone, .convData);

  // 25 MHz clock
  always #20 clk_sys = ~clk_sys;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_tests++;
      if (got !== exp)
      begin
        err_total++;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task rst(input logic [3:0] cnt, input logic lo, input logic hi);
    begin
      @(posedge clk_sys);
      reset_n <= 1'h0;
      countJumper <= cnt;
      rangeLowJumper <= lo;
      rangeHighJumper <= hi;
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'h1;
      repeat (40) @(posedge clk_sys);
    end
  endtask

  task axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    begin
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do @(posedge clk_sys); while (s_axi_awready !== 1'h1);
      s_axi_awvalid <= 1'h0;
      s_axi_wvalid <= 1'h0;
      @(posedge clk_sys);
      s_axi_bready <= 1'h1;
      do @(posedge clk_sys); while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk(s_axi_bresp, er);
    end
  endtask

  task axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    begin
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge clk_sys); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      @(posedge clk_sys);
      s_axi_rready <= 1'h1;
      do @(posedge clk_sys); while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
    end
  endtask

  // One scan, then compare code and sample fields
  task scan(input logic [3:0] k, input logic rng, input logic ckr);
    begin
      hostScan <= 1'h1;
      repeat (4) @(posedge clk_sys);
      hostScan <= 1'h0;
      #1;
      chk(hostWord[15:12], k);
      chk(hostWord[7:0], {k, 4'ha});
      if (ckr)
        chk(hostWord[11:8], {rng, 3'h0});
      repeat (36) @(posedge clk_sys);
    end
  endtask

  task t_default;
    begin
      rst(4'hf, 1'h1, 1'h1);
      for (int i = 0; i < 17; i++)
        scan(4'(i), 1'h1, 1'h1);
      $display("t_default done");
    end
  endtask

  task t_counts;
    logic [3:0] cnts [4];
    logic [3:0] k;
    begin
      cnts = '{4'h0, 4'h1, 4'h7, 4'h8};
      for (int j = 0; j < 4; j++)
      begin
        rst(cnts[j], j[0], !j[0]);
        for (int i = 0; i < cnts[j] + 3; i++)
        begin
          k = 4'(i % (cnts[j] + 1));
          scan(k, k[3] ? !j[0] : j[0], i >= 3);
        end
      end
      $display("t_counts done");
    end
  endtask

  // Registers, buffer fill under freeze
  task t_bus;
    begin
      rst(4'hf, 1'h1, 1'h1);
      axr(4'h4, 32'h3f, 2'h0);
      axr(4'h1, 32'h0, 2'h2);
      axw(4'h2, 32'h1, 2'h2);
      axw(4'h0, 32'h0, 2'h0);
      axr(4'h0, 32'h0, 2'h0);
      scan(4'h0, 1'h1, 1'h1);
      scan(4'h1, 1'h1, 1'h1);
      axr(4'h4, 32'h23f, 2'h0);
      axr(4'h8, 32'h181a, 2'h0);
      axr(4'hc, 32'h2, 2'h0);
      slowMode <= 1'h1;
      axw(4'h0, 32'h3, 2'h0);
      repeat (250) @(posedge clk_sys);
      axr(4'h4, 32'h27f, 2'h0);
      slowMode <= 1'h0;
      $display("t_bus done");
    end
  endtask

  task test_done;
    begin
      $display("Counts: %0d checks, %0d errors", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'h1;
    t_default;
    t_counts;
    t_bus;
    test_done;
  end

  // Watchdog
  initial
  begin
    repeat (12000) @(posedge clk_sys);
    err_total++;
    test_done;
  end
endmodule // mis_word_sequencer_tb_top
